// file: src/see_array_access.sv
// Serial EEPROM slave: array read and page write, protection, hold.
// Assumes serial pins are asynchronous to sys_clk_in and far slower.
//
// Summary of operation
// - Read opcode then sixteen address bits; addressed byte shifts out.
// - Read keeps going, address advances after each byte.
// - Read address wraps from top of array to zero.
// - Raising chip select ends a read at any point.
// - Read ignored while a write cycle runs.
// - Write is opcode, address, data; ends on a byte boundary.
// - Valid write starts timed cycle; busy flag clears when done.
// - More bytes in one select are committed in one cycle.
// - Only low seven address bits advance; page wraps and overwrites.
// - Write rejected without latch, while busy, or on protected page.
// - Lock bit zero: status write allowed whenever latch flag set and not busy.
// - Lock bit one, pin high: status write allowed with latch flag.
// - Lock bit one, pin low: status write always rejected.
// - Hardware lock when lock bit set and pin low, any order.
// - Hardware lock left only by pin going high or by reset.
// - Protect levels: none, C000h up, 8000h up, whole array.
// - Hold pauses transfer without losing bit position.
// - While held, output floats and clock and data are ignored.
// - Hold only entered while selected.
// - Deselect during hold resets state and aborts operation.
// - Hold starts and ends on hold pin edges with clock low.
// - Opcodes read 03h, write 02h; unknown opcode ignored until deselect.
// - Latch flag cleared at reset, disarm, and write completion.
// - Busy flag is one while a timed cycle runs.
`timescale 1ns/1ps
`default_nettype none
`include "see_defs.svh"
module see_array_access
   import see_pkg::*;
(
   input  wire logic       sys_clk_in,
   input  wire logic       rst_in,
   input  wire logic       sel_n_in,
   input  wire logic       sclk_in,
   input  wire logic       sdi_in,
   input  wire logic       hold_n_in,
   input  wire logic       wprot_n_in,
   output logic            sdo_out,
   output logic            sdo_oe_out,
   output logic            busy_flag_out,
   output logic            write_latch_flag_out,
   output logic [1:0]      protect_level_out,
   output logic            status_lock_bit_out,
   output logic            hardware_lock_mode_out
);
   // ==========================================================
   // Pin synchronisers
   logic [4:0] sync1;
   logic [4:0] sync2;
   logic       sel_n;
   logic       sclk;
   logic       sdi;
   logic       hold_n;
   logic       wprot_n;
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         sync1 <= 5'h13;
         sync2 <= 5'h13;
      end else begin
         sync1 <= {sel_n_in, sclk_in, sdi_in, hold_n_in, wprot_n_in};
         sync2 <= sync1;
      end
   end
   assign {sel_n, sclk, sdi, hold_n, wprot_n} = sync2;

   // ==========================================================
   // Edge detect and hold condition
   logic sclk_d;
   logic hold_d;
   logic held;
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         sclk_d <= 1'b0;
         hold_d <= 1'b1;
      end else begin
         sclk_d <= sclk;
         hold_d <= hold_n;
      end
   end
   always_ff @(posedge sys_clk_in) begin
      if (rst_in || sel_n) begin
         held <= 1'b0;
      end else if (!sclk && hold_d && !hold_n) begin
         held <= 1'b1;
      end else if (!sclk && !hold_d && hold_n) begin
         held <= 1'b0;
      end
   end
   logic rise;
   logic fall;
   assign rise = sclk && !sclk_d && !sel_n && !held;
   assign fall = !sclk && sclk_d && !sel_n && !held;

   // ==========================================================
   // Memory and status bits
   logic [7:0]  mem [0:(1 << `SEE_ADDR_W) - 1];
   logic [7:0]  page_buf [0:(1 << `SEE_PAGE_W) - 1];
   logic [(1 << `SEE_PAGE_W) - 1:0] page_dirty;
   logic        busy;
   logic        write_latch_flag;
   logic [1:0]  bp;
   logic        status_lock_bit;
   logic        hardware_lock_mode;
   logic [31:0] wcount;
   logic        commit_arr;
   logic        commit_st;
   logic [7:0]  st_new;
   logic [15:0] page_base;
   logic [6:0]  flush_idx;
   assign hardware_lock_mode = status_lock_bit && !wprot_n;

   function automatic logic prot_hit(input logic [1:0] lvl, input logic [15:0] a);
      logic hit;
      hit = 1'b0;
      if (lvl == 2'h1) begin
         hit = a >= `SEE_PROT_QUARTER;
      end else if (lvl == 2'h2) begin
         hit = a >= `SEE_PROT_HALF;
      end else if (lvl == 2'h3) begin
         hit = a >= `SEE_PROT_ALL;
      end
      return hit;
   endfunction : prot_hit

   // ==========================================================
   // Serial command engine
   see_state_t  state;
   logic [2:0]  bitcnt;
   logic [7:0]  shin;
   logic [7:0]  next_byte;
   logic [15:0] addr;
   logic [7:0]  shout;
   logic        got_data;
   logic        blocked;
   logic        sel_d;
   logic        byte_edge;
   logic [7:0]  shin_hi;
   assign next_byte = {shin[6:0], sdi};
   assign byte_edge = rise && bitcnt == `SEE_LAST_BIT;

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         sel_d <= 1'b1;
      end else begin
         sel_d <= sel_n;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in || sel_n) begin
         state    <= SEE_OPCODE;
         bitcnt   <= 3'h0;
         shin     <= 8'h00;
         got_data <= 1'b0;
         blocked  <= 1'b0;
      end else if (rise) begin
         bitcnt <= bitcnt + 3'h1;
         shin   <= next_byte;
         if (byte_edge) begin
            case (state)
               SEE_OPCODE: begin
                  if (next_byte == `SEE_OP_READ) begin
                     state   <= SEE_ADDR_HI;
                     blocked <= busy;
                  end else if (next_byte == `SEE_OP_WRITE) begin
                     state   <= SEE_ADDR_HI;
                     blocked <= busy || !write_latch_flag;
                     got_data <= 1'b0;
                  end else if (next_byte == `SEE_OP_STATUS_RD) begin
                     state <= SEE_ST_RD;
                  end else if (next_byte == `SEE_OP_STATUS_WR) begin
                     state   <= SEE_ST_WR;
                     blocked <= busy || !write_latch_flag || hardware_lock_mode;
                  end else if (next_byte == `SEE_OP_ARM ||
                               next_byte == `SEE_OP_DISARM) begin
                     state <= SEE_IDLE_WT;
                  end else begin
                     state <= SEE_IDLE_WT;
                     blocked <= 1'b1;
                  end
                  // Remember which command for the address phase
                  got_data <= (next_byte == `SEE_OP_WRITE);
               end
               SEE_ADDR_HI: begin
                  state <= SEE_ADDR_LO;
               end
               SEE_ADDR_LO: begin
                  if (got_data) begin
                     state   <= SEE_WR_DATA;
                     got_data <= 1'b0;
                     if (prot_hit(bp, {shin_hi, next_byte})) begin
                        blocked <= 1'b1;
                     end
                  end else begin
                     state <= SEE_RD_DATA;
                  end
               end
               SEE_WR_DATA: begin
                  got_data <= 1'b1;
               end
               SEE_ST_WR: begin
                  got_data <= 1'b1;
                  state    <= SEE_IDLE_WT;
               end
               default: begin
                  state <= state;
               end
            endcase
         end else if (state == SEE_WR_DATA || state == SEE_IDLE_WT) begin
            got_data <= got_data && state == SEE_IDLE_WT;
         end
      end
   end

   // High address byte kept aside
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         shin_hi <= 8'h00;
      end else if (byte_edge && state == SEE_ADDR_HI) begin
         shin_hi <= next_byte;
      end
   end

   // Address counter and page buffer fill
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         addr <= 16'h0000;
      end else if (byte_edge && state == SEE_ADDR_LO) begin
         addr <= {shin_hi, next_byte};
      end else if (byte_edge && state == SEE_RD_DATA) begin
         addr <= addr + 16'h0001;
      end else if (byte_edge && state == SEE_WR_DATA) begin
         addr <= {addr[15:7], addr[6:0] + 7'h01};
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in || (!sel_n && sel_d && !busy)) begin
         page_dirty <= '0;
      end else if (byte_edge && state == SEE_WR_DATA && !blocked) begin
         page_buf[addr[6:0]]   <= next_byte;
         page_dirty[addr[6:0]] <= 1'b1;
      end
   end

   // Output shifter: load on the last rising edge, shift on falling
   logic load_pending;
   always_ff @(posedge sys_clk_in) begin
      if (rst_in || sel_n) begin
         shout        <= 8'h00;
         load_pending <= 1'b0;
      end else if (byte_edge && (state == SEE_ADDR_LO || state == SEE_RD_DATA)
                   && !got_data && !blocked) begin
         load_pending <= 1'b1;
      end else if (byte_edge && state == SEE_OPCODE &&
                   next_byte == `SEE_OP_STATUS_RD) begin
         shout <= {status_lock_bit, 3'h0, bp, write_latch_flag, busy};
         load_pending <= 1'b0;
      end else if (load_pending) begin
         shout        <= mem[addr];
         load_pending <= 1'b0;
      end else if (fall && bitcnt != 3'h0) begin
         shout <= {shout[6:0], 1'b0};
      end else if (byte_edge && state == SEE_ST_RD) begin
         shout <= {status_lock_bit, 3'h0, bp, write_latch_flag, busy};
      end
   end

   logic drive;
   always_ff @(posedge sys_clk_in) begin
      if (rst_in || sel_n) begin
         drive <= 1'b0;
      end else if (fall && ((state == SEE_RD_DATA && !blocked) || state == SEE_ST_RD)) begin
         drive <= 1'b1;
      end
   end
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         sdo_out <= 1'b0;
      end else if (fall && bitcnt != 3'h0) begin
         sdo_out <= shout[6];
      end else if (fall || sel_n) begin
         sdo_out <= shout[7];
      end
   end
   assign sdo_oe_out = drive && !held && !sel_n;

   // ==========================================================
   // Commit on deselect and self-timed cycle
   logic desel_edge;
   assign desel_edge = sel_n && !sel_d;
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         commit_arr <= 1'b0;
         commit_st  <= 1'b0;
         st_new     <= 8'h00;
      end else begin
         commit_arr <= desel_edge && !held && state == SEE_WR_DATA && got_data
                       && bitcnt == 3'h0 && !blocked && !busy;
         commit_st  <= desel_edge && !held && state == SEE_IDLE_WT && got_data
                       && bitcnt == 3'h0 && !blocked && !busy;
         if (byte_edge && state == SEE_ST_WR) begin
            st_new <= next_byte;
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         busy      <= 1'b0;
         wcount    <= 32'h0;
         page_base <= 16'h0000;
         flush_idx <= 7'h00;
      end else if (commit_arr || commit_st) begin
         busy      <= 1'b1;
         wcount    <= 32'h0;
         page_base <= {addr[15:7], 7'h00};
         flush_idx <= 7'h00;
      end else if (busy) begin
         flush_idx <= flush_idx + 7'h01;
         if (wcount == 32'(`SEE_WRITE_CYCLES) - 32'h1) begin
            busy <= 1'b0;
         end else begin
            wcount <= wcount + 32'h1;
         end
      end
   end

   logic arr_job;
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         arr_job <= 1'b0;
      end else if (commit_arr || commit_st) begin
         arr_job <= commit_arr;
      end
   end
   always_ff @(posedge sys_clk_in) begin
      if (busy && arr_job && wcount < 32'h80 && page_dirty[flush_idx]) begin
         mem[{page_base[15:7], flush_idx}] <= page_buf[flush_idx];
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         bp   <= 2'h0;
         status_lock_bit <= 1'b0;
      end else if (busy && !arr_job && wcount == 32'(`SEE_WRITE_CYCLES) - 32'h1) begin
         bp   <= st_new[3:2];
         status_lock_bit <= st_new[7];
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         write_latch_flag <= 1'b0;
      end else if (desel_edge && !held && state == SEE_IDLE_WT && bitcnt == 3'h0
                   && !blocked && shin == `SEE_OP_ARM) begin
         write_latch_flag <= 1'b1;
      end else if ((desel_edge && !held && state == SEE_IDLE_WT && bitcnt == 3'h0
                    && shin == `SEE_OP_DISARM) ||
                   (busy && wcount == 32'(`SEE_WRITE_CYCLES) - 32'h1)) begin
         write_latch_flag <= 1'b0;
      end
   end

   assign busy_flag_out          = busy;
   assign write_latch_flag_out   = write_latch_flag;
   assign protect_level_out      = bp;
   assign status_lock_bit_out    = status_lock_bit;
   assign hardware_lock_mode_out = hardware_lock_mode;
endmodule : see_array_access
`default_nettype wire

// file: src/see_defs.svh
// Constants for the serial EEPROM array access block.
// Assumes inclusion by the package and the design module only.
`ifndef SEE_DEFS_SVH
`define SEE_DEFS_SVH
`define SEE_OP_READ        8'h03
`define SEE_OP_WRITE       8'h02
`define SEE_OP_ARM         8'h06
`define SEE_OP_DISARM      8'h04
`define SEE_OP_STATUS_RD   8'h05
`define SEE_OP_STATUS_WR   8'h01
`define SEE_ADDR_W         16
`define SEE_PAGE_W         7
`define SEE_ADDR_TOP       16'hFFFF
`define SEE_PROT_QUARTER   16'hC000
`define SEE_PROT_HALF      16'h8000
`define SEE_PROT_ALL       16'h0000
`define SEE_LAST_BIT       3'h7
`define SEE_CYCLE_NS       4
`define SEE_WRITE_TIME_NS  4000
`define SEE_WRITE_CYCLES   (`SEE_WRITE_TIME_NS / `SEE_CYCLE_NS)
`endif

// file: src/see_pkg.sv
// Types for the serial EEPROM array access block.
// Assumes see_defs.svh is on the include path.
`include "see_defs.svh"
package see_pkg;
   typedef enum logic [2:0] {
      SEE_OPCODE   = 3'b000,
      SEE_ADDR_HI  = 3'b001,
      SEE_ADDR_LO  = 3'b011,
      SEE_RD_DATA  = 3'b010,
      SEE_WR_DATA  = 3'b110,
      SEE_ST_RD    = 3'b111,
      SEE_ST_WR    = 3'b101,
      SEE_IDLE_WT  = 3'b100
   } see_state_t;
endpackage : see_pkg

// file: test/see_array_access_monitor.sv
// Checker for the serial EEPROM array access block.
// Assumes it is bound to see_array_access and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module see_array_access_monitor (
   input wire logic       sys_clk_in,
   input wire logic       rst_in,
   input wire logic       sel_n_in,
   input wire logic       sclk_in,
   input wire logic       sdi_in,
   input wire logic       hold_n_in,
   input wire logic       wprot_n_in,
   input wire logic       sdo_out,
   input wire logic       sdo_oe_out,
   input wire logic       busy_flag_out,
   input wire logic       write_latch_flag_out,
   input wire logic [1:0] protect_level_out,
   input wire logic       status_lock_bit_out,
   input wire logic       hardware_lock_mode_out
);
   // ==========================================================
   // Assertions
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (rst_in);
   chk_oe_deselect: assert property (sel_n_in [*4] |-> !sdo_oe_out)
      else $error("data output driven while deselected");
   chk_oe_pause: assert property ((!hold_n_in && !sclk_in) [*6] |-> !sdo_oe_out)
      else $error("data output driven during pause");
   chk_busy_start: assert property ($rose(busy_flag_out) |-> sel_n_in && $past(sel_n_in, 2))
      else $error("write cycle started while selected");
   chk_busy_latch: assert property ($rose(busy_flag_out) |-> $past(write_latch_flag_out))
      else $error("write cycle started without latch flag");
   chk_latch_done: assert property ($fell(busy_flag_out) |-> !write_latch_flag_out)
      else $error("latch flag still set after write cycle");
   chk_lock_enter: assert property (!wprot_n_in [*3] |->
      hardware_lock_mode_out == status_lock_bit_out)
      else $error("lock mode differs from lock bit with pin low");
   chk_lock_leave: assert property (wprot_n_in [*3] |-> !hardware_lock_mode_out)
      else $error("lock mode kept with pin high");
   chk_status_frozen: assert property (!$past(busy_flag_out) |->
      $stable(protect_level_out) && $stable(status_lock_bit_out))
      else $error("status bits changed outside a write cycle");
   chk_sdo_timing: assert property ($past(sdo_oe_out) && sdo_oe_out && $changed(sdo_out) |->
      !sclk_in && !$past(sclk_in, 2))
      else $error("data output changed away from clock fall");
   chk_reset_clear: assert property (disable iff (1'b0) rst_in |=> !busy_flag_out &&
      !write_latch_flag_out && protect_level_out == 2'h0 && !status_lock_bit_out)
      else $error("flags not cleared by reset");
   cover property ($rose(busy_flag_out));
   cover property ($rose(write_latch_flag_out));
   cover property (sdo_oe_out ##1 !hold_n_in);
endmodule : see_array_access_monitor
bind see_array_access see_array_access_monitor u_see_array_access_monitor (
   .sys_clk_in(sys_clk_in), .rst_in(rst_in), .sel_n_in(sel_n_in), .sclk_in(sclk_in),
   .sdi_in(sdi_in), .hold_n_in(hold_n_in), .wprot_n_in(wprot_n_in), .sdo_out(sdo_out),
   .sdo_oe_out(sdo_oe_out), .busy_flag_out(busy_flag_out),
   .write_latch_flag_out(write_latch_flag_out), .protect_level_out(protect_level_out),
   .status_lock_bit_out(status_lock_bit_out), .hardware_lock_mode_out(hardware_lock_mode_out)
);
`default_nettype wire

// file: test/see_host.sv
// Host controller model for the serial pins of the EEPROM block.
// Assumes the bench calls its tasks; pins change just after sys_clk_in rises.
`timescale 1ns/1ps
`default_nettype none
module see_host (
   input  wire logic sys_clk_in,
   input  wire logic sdo_in,
   input  wire logic sdo_oe_in,
   output logic      sel_n_out,
   output logic      sclk_out,
   output logic      sdi_out,
   output logic      hold_n_out
);
   localparam int HALF = 20;
   logic oe_seen;
   logic held_oe;
   initial begin
      sel_n_out = 1'b1;
      sclk_out = 1'b0;
      sdi_out = 1'b0;
      hold_n_out = 1'b1;
      oe_seen = 1'b0;
      held_oe = 1'b0;
   end
   // ==========================================================
   // Frame tasks
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_in);
      #1;
   endtask : tick
   task automatic start();
      tick(1);
      sel_n_out = 1'b0;
      tick(HALF);
   endtask : start
   task automatic bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 0; i < n; i++) begin
         sdi_out = tx[7];
         tx = {tx[6:0], 1'b0};
         tick(HALF);
         sclk_out = 1'b1;
         rx = {rx[6:0], sdo_in};
         oe_seen = oe_seen | sdo_oe_in;
         tick(HALF);
         sclk_out = 1'b0;
      end
   endtask : bits
   task automatic stop();
      tick(HALF);
      sel_n_out = 1'b1;
      sdi_out = ~sdi_out;
      tick(2 * HALF);
   endtask : stop
   task automatic pause(input logic abort);
      tick(4);
      hold_n_out = 1'b0;
      tick(8);
      sclk_out = 1'b1;
      sdi_out = ~sdi_out;
      tick(4);
      held_oe = sdo_oe_in;
      sclk_out = 1'b0;
      tick(8);
      if (abort) begin
         sel_n_out = 1'b1;
         tick(8);
      end
      hold_n_out = 1'b1;
      tick(8);
   endtask : pause
endmodule : see_host
`default_nettype wire

// file: test/tb_see_array_access.sv
// Self-checking bench for the serial EEPROM array access block.
// Assumes see_host drives the serial pins and the monitor is bound.
`timescale 1ns/1ps
`default_nettype none
module tb_see_array_access;
   logic            sys_clk_in;
   logic            rst_in;
   logic            wprot_n_in;
   wire logic       sel_n, sclk, sdi, hold_n, sdo, sdo_oe;
   wire logic       busy, latch, lock, hw_lock;
   wire logic [1:0] level;
   int              fails;
   int              checks_done;
   logic [7:0]      rx, w0, w1, r0, r1;
   see_array_access u_see_array_access (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
      .sel_n_in(sel_n), .sclk_in(sclk), .sdi_in(sdi), .hold_n_in(hold_n),
      .wprot_n_in(wprot_n_in), .sdo_out(sdo), .sdo_oe_out(sdo_oe), .busy_flag_out(busy),
      .write_latch_flag_out(latch), .protect_level_out(level), .status_lock_bit_out(lock),
      .hardware_lock_mode_out(hw_lock));
   see_host u_see_host (.sys_clk_in(sys_clk_in), .sdo_in(sdo), .sdo_oe_in(sdo_oe),
      .sel_n_out(sel_n), .sclk_out(sclk), .sdi_out(sdi), .hold_n_out(hold_n));
   initial begin
      sys_clk_in = 1'b0;
      forever #2 sys_clk_in = ~sys_clk_in;
   end
   // ==========================================================
   // Tasks
   task automatic cmp_bit(input string name, input logic exp, input logic got);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s: expected %b, seen %b", name, exp, got);
      end
   endtask : cmp_bit
   task automatic cmp_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp || $isunknown(got)) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask : cmp_byte
   task automatic hdr(input logic [7:0] op, input logic [15:0] addr);
      u_see_host.start();
      u_see_host.bits(op, 8, rx);
      u_see_host.bits(addr[15:8], 8, rx);
      u_see_host.bits(addr[7:0], 8, rx);
   endtask : hdr
   task automatic rd2(input logic [15:0] addr, output logic [7:0] a, output logic [7:0] b);
      hdr(8'h03, addr);
      u_see_host.bits(8'h00, 8, a);
      u_see_host.bits(8'h00, 8, b);
      u_see_host.stop();
   endtask : rd2
   task automatic cmd(input logic [7:0] op);
      u_see_host.start();
      u_see_host.bits(op, 8, rx);
      u_see_host.stop();
   endtask : cmd
   task automatic wait_idle();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 2000) begin
         u_see_host.tick(1);
         n++;
      end
      cmp_bit("busy", 1'b0, busy);
   endtask : wait_idle
   task automatic finish_test();
      $display("checks %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : finish_test
   initial begin
      #200000;
      fails++;
      $display("unexpected run time: expected end of tests, seen hang");
      finish_test();
   end
   // ==========================================================
   // Tests
   initial begin
      fails = 0;
      checks_done = 0;
      rst_in = 1'b1;
      wprot_n_in = 1'b1;
      repeat (3) @(posedge sys_clk_in);
      #1 rst_in = 1'b0;
      cmp_bit("busy", 1'b0, busy);
      cmp_bit("latch", 1'b0, latch);
      cmd(8'h06);
      hdr(8'h02, 16'hFFFF);
      u_see_host.bits(8'hA1, 8, rx);
      u_see_host.stop();
      wait_idle();
      cmd(8'h06);
      hdr(8'h02, 16'h0000);
      u_see_host.bits(8'hC3, 8, rx);
      u_see_host.bits(8'hD4, 8, rx);
      u_see_host.bits(8'hE5, 8, rx);
      u_see_host.stop();
      wait_idle();
      cmp_bit("latch", 1'b0, latch);
      rd2(16'hFFFF, w0, w1);
      cmp_byte("top byte", 8'hA1, w0);
      rd2(16'h0000, r0, r1);
      cmp_byte("wrapped byte", 8'hC3, w1);
      rd2(16'h0001, w0, w1);
      cmp_byte("next byte", 8'hD4, w0);
      cmp_byte("second byte", 8'hE5, w1);
      cmp_bit("read drive", 1'b1, u_see_host.oe_seen);
      cmp_bit("drive after end", 1'b0, sdo_oe);
      $display("test read done");
      hdr(8'h03, 16'h0000);
      u_see_host.bits(8'h00, 3, w0);
      u_see_host.pause(1'b0);
      u_see_host.bits(8'h00, 5, w1);
      u_see_host.stop();
      cmp_bit("drive in pause", 1'b0, u_see_host.held_oe);
      cmp_byte("paused byte", 8'hC3, {w0[2:0], w1[4:0]});
      $display("test pause done");
      u_see_host.oe_seen = 1'b0;
      u_see_host.start();
      u_see_host.bits(8'hFF, 8, rx);
      u_see_host.bits(8'h00, 8, rx);
      u_see_host.stop();
      cmp_bit("drive after bad opcode", 1'b0, u_see_host.oe_seen);
      cmd(8'h06);
      cmp_bit("latch", 1'b1, latch);
      cmd(8'h04);
      cmp_bit("latch", 1'b0, latch);
      hdr(8'h02, 16'h0010);
      u_see_host.bits(8'hA5, 8, rx);
      u_see_host.stop();
      cmp_bit("busy", 1'b0, busy);
      cmd(8'h06);
      hdr(8'h02, 16'h0010);
      u_see_host.bits(8'hA5, 5, rx);
      u_see_host.stop();
      cmp_bit("busy", 1'b0, busy);
      hdr(8'h02, 16'h0010);
      u_see_host.bits(8'hA5, 8, rx);
      u_see_host.pause(1'b1);
      cmp_bit("busy", 1'b0, busy);
      $display("test refusals done");
      wprot_n_in = 1'b0;
      u_see_host.tick(5);
      cmp_bit("lock mode", 1'b0, hw_lock);
      cmd(8'h06);
      hdr(8'h02, 16'h007F);
      u_see_host.bits(8'h11, 8, rx);
      u_see_host.bits(8'h22, 8, rx);
      u_see_host.stop();
      cmp_bit("busy", 1'b1, busy);
      u_see_host.oe_seen = 1'b0;
      rd2(16'h0000, w0, w1);
      cmp_bit("drive while busy", 1'b0, u_see_host.oe_seen);
      wait_idle();
      rd2(16'h0000, w0, w1);
      cmp_byte("page wrap byte", 8'h22, w0);
      cmp_byte("kept byte", 8'hD4, w1);
      wprot_n_in = 1'b1;
      $display("test write done");
      finish_test();
   end
endmodule : tb_see_array_access
`default_nettype wire
